// ### design/updown_runtime_counters.v
// Purpose: Single-input and dual-input up/down counters and a run-time accumulator
// Assumes: Control inputs synchronous to aclk; AXI4-Lite register access
// Notes:   Count registers are writable to preset them
//
// The AXI4-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "counters_consts.vh"

// Overview of operation
// - Single counter counts up on trigger when direction is high.
// - Single counter counts down on trigger when direction is low.
// - Single counter steps once per trigger rising edge only.
// - Writing single counter value register presets the count.
// - Single counter holds a signed 32-bit two's complement value.
// - Single counter reset input high clears count to zero.
// - Dual counter increments on each up input rising edge, unless down rises in the same cycle.
// - Dual counter decrements on each down input rising edge, unless up rises in the same cycle.
// - Writing dual counter value register presets the count.
// - Dual counter value output is 32 bits wide.
// - Dual counter reset input high clears count to zero.
// - Accumulator counts units of time while activation is high.
// - Accumulator holds total while inactive and resumes from it.
// - Accumulator clears on rising edge of its reset input.
module updown_runtime_counters #(
	parameter [31:0] CYCLES_PER_SECOND = `CYCLES_PER_SECOND
) (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire        single_trigger,
	input  wire        single_direction,
	input  wire        single_reset,
	input  wire        dual_up,
	input  wire        dual_down,
	input  wire        dual_reset,
	input  wire        elapsed_activate,
	input  wire        elapsed_reset,
	output reg  [31:0] single_counter_value,
	output reg  [31:0] dual_counter_value,
	output reg  [31:0] elapsed_time_value,
	input  wire [3:0]  s_axi_awaddr,
	input  wire [2:0]  s_axi_awprot,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [3:0]  s_axi_araddr,
	input  wire [2:0]  s_axi_arprot,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready
);

	// ****************************************
	// Functions
	// ****************************************
	function [31:0] merge_bytes;
		input [31:0] old_value;
		input [31:0] new_value;
		input [3:0]  strobe;
		integer i;
		begin
			merge_bytes = old_value;
			for (i = 0; i < 4; i = i + 1) begin
				if (strobe[i]) begin
					merge_bytes[i*8 +: 8] = new_value[i*8 +: 8];
				end
			end
		end
	endfunction

	function [31:0] step;
		input [31:0] value;
		input        up;
		begin
			step = up ? value + 32'h00000001 : value - 32'h00000001;
		end
	endfunction

	function [3:0] reg_select;
		input [3:0] addr;
		begin
			case (addr)
				`OFF_SINGLE_VALUE:  reg_select = 4'h1;
				`OFF_DUAL_VALUE:    reg_select = 4'h2;
				`OFF_ELAPSED_VALUE: reg_select = 4'h4;
				`OFF_CONTROL:       reg_select = 4'h8;
				default:            reg_select = 4'h0;
			endcase
		end
	endfunction

	function [1:0] access_resp;
		input [3:0] addr;
		begin
			if (reg_select(addr) == 4'h0) begin
				access_resp = `RESP_SLVERR;
			end else begin
				access_resp = `RESP_OKAY;
			end
		end
	endfunction

	// ****************************************
	// Edge detection and time base
	// ****************************************
	wire       trigger_rise;
	wire       up_rise;
	wire       down_rise;
	wire       elapsed_reset_rise;
	wire       unit_done;
	reg  [1:0] control_unit;

	edge_detect u_trigger_edge (
		.aclk    (aclk),
		.aresetn (aresetn),
		.level   (single_trigger),
		.rise    (trigger_rise)
	);

	edge_detect u_up_edge (
		.aclk    (aclk),
		.aresetn (aresetn),
		.level   (dual_up),
		.rise    (up_rise)
	);

	edge_detect u_down_edge (
		.aclk    (aclk),
		.aresetn (aresetn),
		.level   (dual_down),
		.rise    (down_rise)
	);

	edge_detect u_elapsed_reset_edge (
		.aclk    (aclk),
		.aresetn (aresetn),
		.level   (elapsed_reset),
		.rise    (elapsed_reset_rise)
	);

	unit_tick #(
		.CYCLES_PER_SECOND (CYCLES_PER_SECOND)
	) u_unit_tick (
		.aclk    (aclk),
		.aresetn (aresetn),
		.clear   (elapsed_reset_rise),
		.run     (elapsed_activate),
		.unit    (control_unit),
		.tick    (unit_done)
	);

	// ****************************************
	// AXI4-Lite write channel
	// ****************************************
	reg        aw_held;
	reg        w_held;
	reg [3:0]  aw_addr;
	reg [31:0] w_data;
	reg [3:0]  w_strb;
	wire       write_go;
	wire [31:0] single_merged;
	wire [31:0] dual_merged;
	wire [31:0] elapsed_merged;

	assign write_go = aw_held && w_held && !s_axi_bvalid;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held       <= 1'h0;
			w_held        <= 1'h0;
			aw_addr       <= 4'h0;
			w_data        <= 32'h00000000;
			w_strb        <= 4'h0;
			s_axi_awready <= 1'h0;
			s_axi_wready  <= 1'h0;
			s_axi_bvalid  <= 1'h0;
			s_axi_bresp   <= `RESP_OKAY;
		end else begin
			s_axi_awready <= 1'h0;
			s_axi_wready  <= 1'h0;
			if (s_axi_awvalid && !aw_held && !s_axi_awready) begin
				aw_held       <= 1'h1;
				aw_addr       <= s_axi_awaddr;
				s_axi_awready <= 1'h1;
			end
			if (s_axi_wvalid && !w_held && !s_axi_wready) begin
				w_held       <= 1'h1;
				w_data       <= s_axi_wdata;
				w_strb       <= s_axi_wstrb;
				s_axi_wready <= 1'h1;
			end
			if (write_go) begin
				aw_held      <= 1'h0;
				w_held       <= 1'h0;
				s_axi_bvalid <= 1'h1;
				s_axi_bresp  <= access_resp(aw_addr);
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'h0;
			end
		end
	end

	wire [3:0] wr_select  = reg_select(aw_addr);
	wire       wr_single  = write_go && wr_select[0];
	wire       wr_dual    = write_go && wr_select[1];
	wire       wr_elapsed = write_go && wr_select[2];
	wire       wr_control = write_go && wr_select[3];

	assign single_merged  = merge_bytes(single_counter_value, w_data, w_strb);
	assign dual_merged    = merge_bytes(dual_counter_value, w_data, w_strb);
	assign elapsed_merged = merge_bytes(elapsed_time_value, w_data, w_strb);

	always @(posedge aclk) begin
		if (!aresetn) begin
			control_unit <= `UNIT_SECONDS;
		end else if (wr_control && w_strb[0]) begin
			control_unit <= w_data[`CTRL_UNIT_MSB:`CTRL_UNIT_LSB];
		end
	end

	// ****************************************
	// Single-input counter
	// ****************************************
	always @(posedge aclk) begin
		if (!aresetn) begin
			single_counter_value <= 32'h00000000;
		end else if (single_reset) begin
			single_counter_value <= 32'h00000000;
		end else if (wr_single) begin
			single_counter_value <= single_merged;
		end else if (trigger_rise) begin
			// Two's complement add wraps at the signed range
			single_counter_value <= step(single_counter_value, single_direction);
		end
	end

	// ****************************************
	// Dual-input counter
	// ****************************************
	always @(posedge aclk) begin
		if (!aresetn) begin
			dual_counter_value <= 32'h00000000;
		end else if (dual_reset) begin
			dual_counter_value <= 32'h00000000;
		end else if (wr_dual) begin
			dual_counter_value <= dual_merged;
		end else if (up_rise != down_rise) begin
			dual_counter_value <= step(dual_counter_value, up_rise);
		end
	end

	// ****************************************
	// Run-time accumulator
	// ****************************************
	always @(posedge aclk) begin
		if (!aresetn) begin
			elapsed_time_value <= 32'h00000000;
		end else if (elapsed_reset_rise) begin
			elapsed_time_value <= 32'h00000000;
		end else if (wr_elapsed) begin
			elapsed_time_value <= elapsed_merged;
		end else if (unit_done) begin
			// Tick only runs while active, so total holds otherwise
			elapsed_time_value <= elapsed_time_value + 32'h00000001;
		end
	end

	// ****************************************
	// AXI4-Lite read channel
	// ****************************************
	localparam [2:0] RD_IDLE = 3'h1;
	localparam [2:0] RD_ADDR = 3'h2;
	localparam [2:0] RD_DATA = 3'h4;

	reg  [2:0]  rd_state;
	reg  [2:0]  next_rd_state;
	reg  [31:0] next_rdata;
	reg  [1:0]  next_rresp;
	wire [3:0]  rd_select;

	assign rd_select = reg_select(s_axi_araddr);

	always @* begin
		next_rresp = access_resp(s_axi_araddr);
		case (rd_select)
			4'h1:    next_rdata = single_counter_value;
			4'h2:    next_rdata = dual_counter_value;
			4'h4:    next_rdata = elapsed_time_value;
			4'h8:    next_rdata = {30'h00000000, control_unit};
			default: next_rdata = 32'h00000000;
		endcase
	end

	// Read data is offered only after the address handshake
	always @* begin
		case (rd_state)
			RD_IDLE: begin
				if (s_axi_arvalid) begin
					next_rd_state = RD_ADDR;
				end else begin
					next_rd_state = RD_IDLE;
				end
			end
			RD_ADDR: begin
				next_rd_state = RD_DATA;
			end
			RD_DATA: begin
				if (s_axi_rready) begin
					next_rd_state = RD_IDLE;
				end else begin
					next_rd_state = RD_DATA;
				end
			end
			default: begin
				next_rd_state = RD_IDLE;
			end
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			rd_state      <= RD_IDLE;
			s_axi_arready <= 1'h0;
			s_axi_rvalid  <= 1'h0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `RESP_OKAY;
		end else begin
			rd_state      <= next_rd_state;
			s_axi_arready <= (next_rd_state == RD_ADDR);
			s_axi_rvalid  <= (next_rd_state == RD_DATA);
			if (rd_state == RD_ADDR) begin
				s_axi_rdata <= next_rdata;
				s_axi_rresp <= next_rresp;
			end
		end
	end
endmodule // updown_runtime_counters

// ### design/counters_consts.vh
// Purpose: Constants for the up/down and run-time counter block
// Assumes: 25 MHz system clock
// Notes:   Register offsets are byte addresses on the AXI4-Lite slave
`ifndef COUNTERS_CONSTS_VH
`define COUNTERS_CONSTS_VH

`define CLK_PERIOD_NS      40
`define CLK_FREQ_HZ        25000000
`define SECOND_NS          1000000000
`define CYCLES_PER_SECOND  (`SECOND_NS / `CLK_PERIOD_NS)
`define SECONDS_PER_MINUTE 12'h03C
`define MINUTES_PER_HOUR   12'h03C

`define UNIT_SECONDS       2'h0
`define UNIT_MINUTES       2'h1
`define UNIT_HOURS         2'h2

`define OFF_SINGLE_VALUE   4'h0
`define OFF_DUAL_VALUE     4'h4
`define OFF_ELAPSED_VALUE  4'h8
`define OFF_CONTROL        4'hC

`define CTRL_UNIT_LSB      0
`define CTRL_UNIT_MSB      1
`define CTRL_RESET_VALUE   32'h00000000

`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// ### design/edge_detect.v
// Purpose: Rising edge detector for a synchronous level input
// Assumes: Input synchronous to aclk
// Notes:   Pulse is one cycle long
`timescale 1ns/1ps
module edge_detect (
	input  wire aclk,
	input  wire aresetn,
	input  wire level,
	output wire rise
);
	reg last;

	always @(posedge aclk) begin
		if (!aresetn) begin
			last <= 1'h0;
		end else begin
			last <= level;
		end
	end

	assign rise = level & ~last;
endmodule // edge_detect

// ### design/unit_tick.v
// Purpose: Prescaler giving one pulse per elapsed time unit
// Assumes: Enabled only while the accumulator is active
// Notes:   Partial progress is kept while disabled
`timescale 1ns/1ps
`include "counters_consts.vh"
module unit_tick #(
	parameter [31:0] CYCLES_PER_SECOND = `CYCLES_PER_SECOND
) (
	input  wire       aclk,
	input  wire       aresetn,
	input  wire       clear,
	input  wire       run,
	input  wire [1:0] unit,
	output wire       tick
);
	reg  [31:0] cycle_count;
	reg  [11:0] second_count;
	wire        second_tick;
	reg  [11:0] unit_seconds;

	always @* begin
		case (unit)
			`UNIT_MINUTES: unit_seconds = `SECONDS_PER_MINUTE;
			`UNIT_HOURS:   unit_seconds = `SECONDS_PER_MINUTE * `MINUTES_PER_HOUR;
			default:       unit_seconds = 12'h001;
		endcase
	end

	assign second_tick = run && (cycle_count == CYCLES_PER_SECOND - 32'h00000001);
	assign tick = second_tick && (second_count == unit_seconds - 12'h001);

	always @(posedge aclk) begin
		if (!aresetn || clear) begin
			cycle_count  <= 32'h00000000;
			second_count <= 12'h000;
		end else if (run) begin
			if (second_tick) begin
				cycle_count <= 32'h00000000;
				if (tick || second_count >= unit_seconds) begin
					second_count <= 12'h000;
				end else begin
					second_count <= second_count + 12'h001;
				end
			end else begin
				cycle_count <= cycle_count + 32'h00000001;
			end
		end
	end
endmodule // unit_tick

// ### dv/ctrl_model.sv
// Purpose: Control program model driving the pulse inputs
// Assumes: Requests last one cycle, with gaps between them
// Notes:   Each pulse lags its request by one cycle
`timescale 1ns/1ps
module ctrl_model (
	input  wire       aclk,
	input  wire [2:0] req,
	output reg        single_trigger,
	output reg        dual_up,
	output reg        dual_down
);
	initial {dual_down, dual_up, single_trigger} = 3'h0;
	always @(posedge aclk) begin
		{dual_down, dual_up, single_trigger} <= req;
	end
endmodule // ctrl_model

// ### dv/counters_monitor.sv
// Purpose: Checker for the counter block
// Assumes: Bound to the top module
// Notes:   Bus writes mask the count checks
`timescale 1ns/1ps
module counters_monitor (
	input wire        aclk,
	input wire        aresetn,
	input wire        single_trigger,
	input wire        single_direction,
	input wire        single_reset,
	input wire        dual_up,
	input wire        dual_down,
	input wire        dual_reset,
	input wire        elapsed_activate,
	input wire        elapsed_reset,
	input wire [31:0] single_counter_value,
	input wire [31:0] dual_counter_value,
	input wire [31:0] elapsed_time_value,
	input wire        s_axi_awvalid,
	input wire        s_axi_wvalid
);
	// ****
	// Properties
	// ****
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire q = !s_axi_awvalid && !s_axi_wvalid;
	single_step_a:
	assert property ($rose(single_trigger) && !single_reset && q |=> single_counter_value ==
		$past(single_counter_value) + ($past(single_direction) ? 32'h1 : 32'hFFFFFFFF)) else $error("single step");
	single_clear_a:
	assert property (single_reset |=> single_counter_value == 32'h0) else $error("single clear");
	dual_up_a:
	assert property ($rose(dual_up) && !$rose(dual_down) && !dual_reset && q |=>
		dual_counter_value == $past(dual_counter_value) + 32'h1) else $error("dual up");
	dual_down_a:
	assert property ($rose(dual_down) && !$rose(dual_up) && !dual_reset && q |=>
		dual_counter_value == $past(dual_counter_value) - 32'h1) else $error("dual down");
	dual_both_a:
	assert property ($rose(dual_up) && $rose(dual_down) && !dual_reset && q |=>
		$stable(dual_counter_value)) else $error("dual both");
	dual_clear_a:
	assert property (dual_reset |=> dual_counter_value == 32'h0) else $error("dual clear");
	elapsed_clear_a:
	assert property ($rose(elapsed_reset) |=> elapsed_time_value == 32'h0) else $error("elapsed clear");
	elapsed_hold_a:
	assert property (!elapsed_activate && !$past(elapsed_activate) && !$rose(elapsed_reset) && q |=>
		$stable(elapsed_time_value)) else $error("elapsed hold");
	cover property ($rose(single_trigger) && single_direction);
	cover property ($rose(dual_up) && $rose(dual_down));
	cover property (elapsed_activate && $rose(elapsed_time_value[0]));
endmodule // counters_monitor
bind updown_runtime_counters counters_monitor mon (.*);

// ### dv/test_updown_runtime_counters.sv
// Purpose: Self-checking bench for the counter block
// Assumes: Short prescale count
// Notes:   Reference counts kept as integers
`timescale 1ns/1ps
`include "counters_consts.vh"
module test_updown_runtime_counters;
	localparam CPS = 4;
	reg aclk = 0, aresetn = 0, dir = 0, sr = 0, dr = 0, act = 0, er = 0;
	reg awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	reg [2:0] req = 0;
	reg [3:0] awaddr = 0, araddr = 0;
	reg [31:0] wdata = 0, d;
	reg [1:0] r;
	wire trg, up, dn, awready, wready, bvalid, arready, rvalid;
	wire [1:0] bresp, rresp;
	wire [31:0] sv, dv, ev, rdata;
	integer n_fail = 0, n_compared = 0, es = 0, ed = 0, i, n;
	initial forever #20 aclk = ~aclk;
	ctrl_model cm (.aclk(aclk), .req(req), .single_trigger(trg), .dual_up(up), .dual_down(dn));
	updown_runtime_counters #(.CYCLES_PER_SECOND(CPS)) dut (.aclk(aclk), .aresetn(aresetn),
		.single_trigger(trg), .single_direction(dir), .single_reset(sr), .dual_up(up), .dual_down(dn),
		.dual_reset(dr), .elapsed_activate(act), .elapsed_reset(er), .single_counter_value(sv),
		.dual_counter_value(dv), .elapsed_time_value(ev), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));
	// ****
	// Tasks
	// ****
	task chk(input [31:0] got, input [31:0] exp);
		begin
			n_compared = n_compared + 1;
			if (got !== exp) begin
				n_fail = n_fail + 1;
				$display("BAD %0t got %h want %h", $time, got, exp);
			end
		end
	endtask
	task tick(input integer k);
		repeat (k) @(posedge aclk);
	endtask
	task wr(input [3:0] a, input [31:0] v);
		begin
			@(posedge aclk);
			awaddr <= a;
			wdata <= v;
			awvalid <= 1'h1;
			wvalid <= 1'h1;
			bready <= 1'h1;
			r = 2'h3;
			while (r === 2'h3) begin
				@(posedge aclk);
				if (awready) awvalid <= 1'h0;
				if (wready) wvalid <= 1'h0;
				if (bvalid) r = bresp;
			end
			bready <= 1'h0;
		end
	endtask
	task rd(input [3:0] a);
		begin
			@(posedge aclk);
			araddr <= a;
			arvalid <= 1'h1;
			rready <= 1'h1;
			r = 2'h3;
			while (r === 2'h3) begin
				@(posedge aclk);
				if (arready) arvalid <= 1'h0;
				if (rvalid) d = rdata;
				if (rvalid) r = rresp;
			end
			rready <= 1'h0;
		end
	endtask
	task pulse(input [2:0] p, input v);
		begin
			@(posedge aclk);
			req <= p;
			dir <= v;
			@(posedge aclk);
			req <= 3'h0;
			tick(3);
		end
	endtask
	task conclude;
		begin
			$display("compared %0d failed %0d", n_compared, n_fail);
			if (n_fail == 0 && n_compared > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask
	initial begin
		#2000000;
		n_fail = n_fail + 1;
		conclude;
	end
	// ****
	// Sequence
	// ****
	initial begin
		void'($urandom(56));
		tick(2);
		aresetn <= 1'h1;
		for (i = 0; i < 16; i = i + 4) begin
			rd(i[3:0]);
			chk(d, 32'h0);
		end
		for (i = 0; i < 12; i = i + 1) begin
			d = $urandom;
			pulse(3'h1, d[0]);
			es = d[0] ? es + 1 : es - 1;
			chk(sv, es);
			pulse({d[2], d[1], 1'h0}, d[0]);
			ed = ed + d[1] - d[2];
			chk(dv, ed);
		end
		wr(4'h0, 32'h7FFFFFFF);
		chk(r, `RESP_OKAY);
		pulse(3'h1, 1'h1);
		chk(sv, 32'h80000000);
		d = $urandom;
		wr(4'h4, d);
		pulse(3'h4, 1'h0);
		chk(dv, d - 1);
		wr(4'h4, 32'h0);
		pulse(3'h4, 1'h0);
		chk(dv, 32'hFFFFFFFF);
		wr(4'h2, 32'h5);
		chk(r, `RESP_SLVERR);
		rd(4'h1);
		chk(r, `RESP_SLVERR);
		rd(4'h0);
		chk(d, 32'h80000000);
		@(posedge aclk);
		sr <= 1'h1;
		dr <= 1'h1;
		pulse(3'h3, 1'h1);
		sr <= 1'h0;
		dr <= 1'h0;
		chk(sv, 32'h0);
		chk(dv, 32'h0);
		act <= 1'h1;
		tick(10);
		act <= 1'h0;
		tick(20);
		chk(ev, 32'h2);
		act <= 1'h1;
		tick(8);
		act <= 1'h0;
		tick(3);
		rd(4'h8);
		chk(d, 32'h4);
		for (i = 1; i < 3; i = i + 1) begin
			wr(4'hC, i);
			er <= 1'h1;
			tick(1);
			er <= 1'h0;
			tick(2);
			chk(ev, 32'h0);
			n = i == 1 ? CPS * 60 : CPS * 3600;
			act <= 1'h1;
			tick(n + n / 2);
			act <= 1'h0;
			tick(3);
			chk(ev, 32'h1);
		end
		conclude;
	end
endmodule // test_updown_runtime_counters
